// ===== msoh_pkg.sv
// Shared constants for the STM-0 overhead channel block.
package msoh_pkg;
   localparam int          CLK_HZ       = 250_000_000;
   localparam int          OW_RATE_HZ   = 64_000;
   localparam logic [11:0] OW_BIT_LAST  = 12'(CLK_HZ / OW_RATE_HZ - 1);
   localparam int          OW_WANDER_NS = 18_000;
   localparam int          OW_DEPTH     = 8;
   localparam int          OW_AW        = 3;
   localparam logic [7:0]  OW_IDLE      = 8'hFF;
   localparam logic [3:0]  ROW_LAST     = 4'h8;
   localparam logic [6:0]  COL_LAST     = 7'h59;
   localparam logic [6:0]  OH_COL_LAST  = 7'h02;
   localparam logic [3:0]  K2_ROW       = 4'h4;
   localparam logic [6:0]  K2_COL       = 7'h02;
   localparam logic [3:0]  DCC_ROW_LO   = 4'h5;
   localparam logic [3:0]  DCC_ROW_HI   = 4'h7;
   localparam logic [3:0]  E2_ROW       = 4'h8;
   localparam logic [6:0]  M1_COL       = 7'h01;
   localparam logic [6:0]  E2_COL       = 7'h02;
   localparam logic [2:0]  K2_AIS       = 3'h7;
   localparam logic [2:0]  K2_RDI       = 3'h6;
   localparam logic [2:0]  AIS_FRAMES   = 3'h3;
   localparam logic [7:0]  ADR_CTRL     = 8'h00;
   localparam logic [7:0]  ADR_FAULT    = 8'h04;
   localparam logic [7:0]  ADR_IRQ      = 8'h08;
   localparam logic [7:0]  ADR_MASK     = 8'h0C;
   localparam logic [7:0]  ADR_NEAR_EBC = 8'h10;
   localparam logic [7:0]  ADR_FAR_EBC  = 8'h14;
   localparam logic [7:0]  ADR_DS       = 8'h18;
   localparam int          CTRL_MON     = 0;
   localparam int          CTRL_AIS     = 1;
   localparam int          CTRL_RDI     = 2;
   localparam int          CTRL_SSF     = 3;
   localparam logic [3:0]  CTRL_RST     = 4'h0;
   localparam int          FLT_AIS      = 0;
   localparam int          FLT_DEG      = 1;
   localparam int          FLT_RDI      = 2;
   localparam int          FLT_SSF      = 3;
   localparam int          IRQ_SLIP     = 4;
   localparam logic [4:0]  MASK_RST     = 5'h00;
endpackage

// ===== ow_fifo_if.sv
// Orderwire octet store connection.
`timescale 1ns/1ps
interface ow_fifo_if;
   logic       wr_en;
   logic [7:0] wr_data;
   logic       full;
   logic       rd_en;
   logic [7:0] rd_data;
   logic       empty;
   modport store (input wr_en, wr_data, rd_en, output full, rd_data, empty);
   modport user (output wr_en, wr_data, rd_en, input full, rd_data, empty);
endinterface

// ===== ow_store.sv
// Orderwire elastic octet store with registered read data.
`timescale 1ns/1ps
module ow_store (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   ow_fifo_if.store  f
);
   logic [7:0]                 mem [msoh_pkg::OW_DEPTH];
   logic [msoh_pkg::OW_AW-1:0] wp_reg;
   logic [msoh_pkg::OW_AW-1:0] rp_reg;
   logic [msoh_pkg::OW_AW:0]   cnt_reg;
   logic                       wr_ok;
   logic                       rd_ok;

   assign wr_ok   = f.wr_en && !f.full;
   assign rd_ok   = f.rd_en && !f.empty;
   assign f.full  = cnt_reg == (msoh_pkg::OW_AW+1)'(msoh_pkg::OW_DEPTH);
   assign f.empty = cnt_reg == '0;

   always_ff @(posedge i_clk) begin
      if (wr_ok) begin
         mem[wp_reg] <= f.wr_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wp_reg    <= '0;
         rp_reg    <= '0;
         cnt_reg   <= '0;
         f.rd_data <= '0;
      end else begin
         if (wr_ok) begin
            wp_reg <= wp_reg + 1'b1;
         end
         if (rd_ok) begin
            rp_reg    <= rp_reg + 1'b1;
            f.rd_data <= mem[rp_reg];
         end
         cnt_reg <= cnt_reg + {3'h0, wr_ok} - {3'h0, rd_ok};
      end
   end

   property p_no_overrun;
      @(posedge i_clk) disable iff (!i_rst_n)
      f.full && f.wr_en && !f.rd_en |=> f.full && cnt_reg == $past(cnt_reg);
   endproperty
   a_no_overrun: assert property (p_no_overrun) else $error("Store overrun.");
endmodule

// ===== ow_serial.sv
// Orderwire sink octet latch and 64 kbit/s serialiser.
`timescale 1ns/1ps
module ow_serial (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_load,
   input  wire logic [7:0] i_octet,
   input  wire logic       i_trail_sf,
   output logic            o_tick,
   output logic            o_fs,
   output logic            o_data,
   output logic            o_sf
);
   logic [7:0]  store_reg;
   logic [7:0]  sh_reg;
   logic [7:0]  cur;
   logic [11:0] div_reg;
   logic [2:0]  bit_reg;
   logic        tick;

   assign tick = div_reg == msoh_pkg::OW_BIT_LAST;
   assign cur  = (bit_reg == 3'h0) ? store_reg : sh_reg;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         store_reg <= msoh_pkg::OW_IDLE;
      end else if (i_load) begin
         store_reg <= i_octet;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_reg <= '0;
         bit_reg <= '0;
         sh_reg  <= '0;
         o_data  <= 1'b1;
         o_tick  <= 1'b0;
         o_fs    <= 1'b0;
         o_sf    <= 1'b0;
      end else begin
         div_reg <= tick ? 12'h000 : div_reg + 12'h001;
         o_tick  <= tick;
         o_fs    <= tick && bit_reg == 3'h0;
         o_sf    <= i_trail_sf;
         if (tick) begin
            bit_reg <= bit_reg + 3'h1;
            sh_reg  <= {cur[6:0], 1'b0};
            o_data  <= i_trail_sf | cur[7];
         end
      end
   end

   property p_ones;
      @(posedge i_clk) disable iff (!i_rst_n)
      tick && i_trail_sf |=> o_tick && o_data && o_sf;
   endproperty
   a_ones: assert property (p_ones) else $error("No all-ones on fail.");
endmodule

// ===== msoh_top.sv
// STM-0 multiplex section overhead correlation, monitoring and channel access.
//
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
module msoh_top (
   input  wire logic        I_REF_CLK,
   input  wire logic        I_RESET_N,
   input  wire logic        I_WB_CYC,
   input  wire logic        I_WB_STB,
   input  wire logic        I_WB_WE,
   input  wire logic [7:0]  I_WB_ADR,
   input  wire logic [31:0] I_WB_DAT,
   input  wire logic [3:0]  I_WB_SEL,
   output logic      [31:0] O_WB_DAT,
   output logic             O_WB_ACK,
   output logic             O_IRQ,
   input  wire logic        I_RX_VLD,
   input  wire logic        I_RX_FS,
   input  wire logic [7:0]  I_RX_DATA,
   input  wire logic        I_TRAIL_SF,
   input  wire logic        I_INCOMING_SF,
   input  wire logic        I_DEGRADED_DEFECT,
   input  wire logic        I_EQUIPMENT_DEFECT,
   input  wire logic        I_BLK_VLD,
   input  wire logic [3:0]  I_NEAR_BLOCK_ERRORS,
   input  wire logic [3:0]  I_FAR_BLOCK_ERRORS,
   output logic             O_ALARM_FAULT,
   output logic             O_DEGRADED_FAULT,
   output logic             O_REMOTE_FAULT,
   output logic             O_SERVER_FAIL_FAULT,
   output logic             O_NEAR_DEFECT_SECOND,
   output logic             O_FAR_DEFECT_SECOND,
   output logic             O_TRAIL_SF,
   input  wire logic        I_TX_VLD,
   input  wire logic        I_TX_FS,
   input  wire logic [7:0]  I_TX_DATA,
   output logic             O_TX_VLD,
   output logic      [7:0]  O_TX_DATA,
   output logic             O_DCC_TX_REQ,
   input  wire logic [7:0]  I_DCC_TX_DATA,
   output logic             O_DCC_RX_VLD,
   output logic      [7:0]  O_DCC_RX_DATA,
   output logic             O_DCC_RX_SF,
   input  wire logic        I_OW_CLK,
   input  wire logic        I_OW_FS,
   input  wire logic        I_OW_DATA,
   output logic             O_OW_RX_CLK,
   output logic             O_OW_RX_FS,
   output logic             O_OW_RX_DATA,
   output logic             O_OW_RX_SF
);
   typedef logic [10:0] pos_t;
   localparam logic [2:0] PAT [2] = '{msoh_pkg::K2_AIS, msoh_pkg::K2_RDI};

   // --------------------
   // Frame position
   // --------------------
   function automatic logic at(pos_t p, logic [3:0] r, logic [6:0] c);
      return p == {r, c};
   endfunction

   function automatic logic in_dcc(pos_t p);
      return p[10:7] >= msoh_pkg::DCC_ROW_LO && p[10:7] <= msoh_pkg::DCC_ROW_HI
             && p[6:0] <= msoh_pkg::OH_COL_LAST;
   endfunction

   function automatic pos_t step(pos_t p);
      if (p[6:0] != msoh_pkg::COL_LAST) begin
         return {p[10:7], p[6:0] + 7'h01};
      end
      if (p[10:7] != msoh_pkg::ROW_LAST) begin
         return {p[10:7] + 4'h1, 7'h00};
      end
      return '0;
   endfunction

   pos_t rpos_reg;
   pos_t tpos_reg;
   pos_t rpos;
   pos_t tpos;
   logic rx_k2;
   logic rx_e2;
   logic rx_dcc;
   logic tx_m1;
   logic tx_e2;
   logic tx_dcc;

   assign rpos   = I_RX_FS ? '0 : rpos_reg;
   assign tpos   = I_TX_FS ? '0 : tpos_reg;
   assign rx_k2  = I_RX_VLD && at(rpos, msoh_pkg::K2_ROW, msoh_pkg::K2_COL);
   assign rx_e2  = I_RX_VLD && at(rpos, msoh_pkg::E2_ROW, msoh_pkg::E2_COL);
   assign rx_dcc = I_RX_VLD && in_dcc(rpos);
   assign tx_m1  = I_TX_VLD && at(tpos, msoh_pkg::E2_ROW, msoh_pkg::M1_COL);
   assign tx_e2  = I_TX_VLD && at(tpos, msoh_pkg::E2_ROW, msoh_pkg::E2_COL);
   assign tx_dcc = I_TX_VLD && in_dcc(tpos);

   always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         rpos_reg <= '0;
         tpos_reg <= '0;
      end else begin
         if (I_RX_VLD) begin
            rpos_reg <= step(rpos);
         end
         if (I_TX_VLD) begin
            tpos_reg <= step(tpos);
         end
      end
   end

   // --------------------
   // K2 defect filters
   // --------------------
   logic [1:0] defect;
   logic       alarm_indication_defect;
   logic       remote_defect_defect;

   for (genvar g = 0; g < 2; g++) begin : g_def
      logic [2:0] cnt_reg;
      logic       d_reg;
      logic       hit;
      assign hit       = I_RX_DATA[2:0] == PAT[g];
      assign defect[g] = d_reg;
      always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
         if (!I_RESET_N) begin
            cnt_reg <= '0;
            d_reg   <= 1'b0;
         end else if (rx_k2) begin
            if (hit == d_reg) begin
               cnt_reg <= '0;
            end else if (cnt_reg == msoh_pkg::AIS_FRAMES - 3'h1) begin
               d_reg   <= hit;
               cnt_reg <= '0;
            end else begin
               cnt_reg <= cnt_reg + 3'h1;
            end
         end
      end
   end

   assign alarm_indication_defect       = defect[0];
   assign remote_defect_defect       = defect[1];
   assign O_TRAIL_SF = alarm_indication_defect;

   // --------------------
   // Fault correlation and monitoring
   // --------------------
   logic [3:0]  ctrl_reg;
   logic [3:0]  flt_reg;
   logic [3:0]  flt_next;
   logic        mon;
   logic        nds_reg;
   logic        fds_reg;

   assign mon = ctrl_reg[msoh_pkg::CTRL_MON];

   always_comb begin
      flt_next                    = '0;
      flt_next[msoh_pkg::FLT_AIS] = mon && alarm_indication_defect && !I_INCOMING_SF
                                    && ctrl_reg[msoh_pkg::CTRL_AIS];
      flt_next[msoh_pkg::FLT_DEG] = mon && I_DEGRADED_DEFECT;
      flt_next[msoh_pkg::FLT_RDI] = mon && remote_defect_defect && ctrl_reg[msoh_pkg::CTRL_RDI];
      flt_next[msoh_pkg::FLT_SSF] = mon && alarm_indication_defect && ctrl_reg[msoh_pkg::CTRL_SSF];
   end

   always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         flt_reg <= '0;
         nds_reg <= 1'b0;
         fds_reg <= 1'b0;
      end else begin
         flt_reg <= flt_next;
         nds_reg <= alarm_indication_defect | I_EQUIPMENT_DEFECT;
         fds_reg <= remote_defect_defect;
      end
   end

   assign O_ALARM_FAULT        = flt_reg[msoh_pkg::FLT_AIS];
   assign O_DEGRADED_FAULT     = flt_reg[msoh_pkg::FLT_DEG];
   assign O_REMOTE_FAULT       = flt_reg[msoh_pkg::FLT_RDI];
   assign O_SERVER_FAIL_FAULT  = flt_reg[msoh_pkg::FLT_SSF];
   assign O_NEAR_DEFECT_SECOND = nds_reg;
   assign O_FAR_DEFECT_SECOND  = fds_reg;

   // --------------------
   // Register bus
   // --------------------
   logic [4:0]  mask_reg;
   logic [4:0]  irq_reg;
   logic [4:0]  ev;
   logic [31:0] neb_reg;
   logic [31:0] feb_reg;
   logic [1:0]  ds_reg;
   logic        ack_reg;
   logic        wb_rd;
   logic        wb_wr;
   logic        slip;

   assign wb_rd    = I_WB_CYC && I_WB_STB && !ack_reg && !I_WB_WE;
   assign wb_wr    = I_WB_CYC && I_WB_STB && !ack_reg && I_WB_WE && I_WB_SEL[0];
   assign ev       = {slip, flt_next & ~flt_reg};
   assign O_WB_ACK = ack_reg;
   assign O_IRQ    = |(irq_reg & mask_reg);

   always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         ack_reg  <= 1'b0;
         O_WB_DAT <= '0;
      end else begin
         ack_reg <= I_WB_CYC && I_WB_STB && !ack_reg;
         if (wb_rd) begin
            case (I_WB_ADR)
               msoh_pkg::ADR_CTRL:     O_WB_DAT <= {28'h0, ctrl_reg};
               msoh_pkg::ADR_FAULT:    O_WB_DAT <= {26'h0, remote_defect_defect, alarm_indication_defect, flt_reg};
               msoh_pkg::ADR_IRQ:      O_WB_DAT <= {27'h0, irq_reg};
               msoh_pkg::ADR_MASK:     O_WB_DAT <= {27'h0, mask_reg};
               msoh_pkg::ADR_NEAR_EBC: O_WB_DAT <= neb_reg;
               msoh_pkg::ADR_FAR_EBC:  O_WB_DAT <= feb_reg;
               msoh_pkg::ADR_DS:       O_WB_DAT <= {30'h0, ds_reg};
               default:                O_WB_DAT <= '0;
            endcase
         end
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         ctrl_reg <= msoh_pkg::CTRL_RST;
         mask_reg <= msoh_pkg::MASK_RST;
      end else if (wb_wr) begin
         if (I_WB_ADR == msoh_pkg::ADR_CTRL) begin
            ctrl_reg <= I_WB_DAT[3:0];
         end
         if (I_WB_ADR == msoh_pkg::ADR_MASK) begin
            mask_reg <= I_WB_DAT[4:0];
         end
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         irq_reg <= '0;
         ds_reg  <= '0;
      end else begin
         irq_reg <= ((wb_rd && I_WB_ADR == msoh_pkg::ADR_IRQ) ? 5'h00 : irq_reg) | ev;
         ds_reg  <= ((wb_rd && I_WB_ADR == msoh_pkg::ADR_DS) ? 2'h0 : ds_reg)
                    | {fds_reg, nds_reg};
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         neb_reg <= '0;
         feb_reg <= '0;
      end else begin
         neb_reg <= ((wb_rd && I_WB_ADR == msoh_pkg::ADR_NEAR_EBC) ? 32'h0 : neb_reg)
                    + (I_BLK_VLD ? {28'h0, I_NEAR_BLOCK_ERRORS} : 32'h0);
         feb_reg <= ((wb_rd && I_WB_ADR == msoh_pkg::ADR_FAR_EBC) ? 32'h0 : feb_reg)
                    + (I_BLK_VLD ? {28'h0, I_FAR_BLOCK_ERRORS} : 32'h0);
      end
   end

   // --------------------
   // Data channel and orderwire sink
   // --------------------
   assign O_DCC_RX_SF = I_TRAIL_SF;

   always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_DCC_RX_VLD  <= 1'b0;
         O_DCC_RX_DATA <= '0;
      end else begin
         O_DCC_RX_VLD <= rx_dcc;
         if (rx_dcc) begin
            O_DCC_RX_DATA <= I_RX_DATA;
         end
      end
   end

   ow_serial u_ow_serial (
      .i_clk      (I_REF_CLK),
      .i_rst_n    (I_RESET_N),
      .i_load     (rx_e2),
      .i_octet    (I_RX_DATA),
      .i_trail_sf (I_TRAIL_SF),
      .o_tick     (O_OW_RX_CLK),
      .o_fs       (O_OW_RX_FS),
      .o_data     (O_OW_RX_DATA),
      .o_sf       (O_OW_RX_SF)
   );

   // --------------------
   // Source insertion
   // --------------------
   ow_fifo_if f ();
   logic [2:0] owck_s;
   logic [1:0] owfs_s;
   logic [1:0] owd_s;
   logic [7:0] oct_reg;
   logic [2:0] obit_reg;
   logic [2:0] oidx;
   logic       ow_edge;
   logic       ow_wr_reg;
   logic       have_reg;

   assign ow_edge   = owck_s[1] && !owck_s[2];
   assign oidx      = owfs_s[1] ? 3'h0 : obit_reg;
   assign f.wr_en   = ow_wr_reg;
   assign f.wr_data = oct_reg;
   assign f.rd_en   = tx_m1 && !f.empty;
   assign slip      = (ow_wr_reg && f.full) || (tx_m1 && f.empty);
   assign O_DCC_TX_REQ = tx_dcc;

   always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         owck_s    <= '0;
         owfs_s    <= '0;
         owd_s     <= '0;
         oct_reg   <= '0;
         obit_reg  <= '0;
         ow_wr_reg <= 1'b0;
      end else begin
         owck_s    <= {owck_s[1:0], I_OW_CLK};
         owfs_s    <= {owfs_s[0], I_OW_FS};
         owd_s     <= {owd_s[0], I_OW_DATA};
         ow_wr_reg <= ow_edge && oidx == 3'h7;
         if (ow_edge) begin
            oct_reg  <= {oct_reg[6:0], owd_s[1]};
            obit_reg <= oidx + 3'h1;
         end
      end
   end

   ow_store u_ow_store (
      .i_clk   (I_REF_CLK),
      .i_rst_n (I_RESET_N),
      .f       (f)
   );

   always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         have_reg  <= 1'b0;
         O_TX_VLD  <= 1'b0;
         O_TX_DATA <= '0;
      end else begin
         if (tx_m1) begin
            have_reg <= !f.empty;
         end
         O_TX_VLD <= I_TX_VLD;
         if (tx_dcc) begin
            O_TX_DATA <= I_DCC_TX_DATA;
         end else if (tx_e2) begin
            O_TX_DATA <= have_reg ? f.rd_data : msoh_pkg::OW_IDLE;
         end else begin
            O_TX_DATA <= I_TX_DATA;
         end
      end
   end

   // --------------------
   // Checks
   // --------------------
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RESET_N);

   sequence s_wb_req;
      I_WB_CYC && I_WB_STB && !O_WB_ACK;
   endsequence
   sequence s_ack_once;
      O_WB_ACK ##1 !O_WB_ACK;
   endsequence

   property p_wb_ack;
      s_wb_req |=> s_ack_once;
   endproperty
   property p_ais_fault;
      O_ALARM_FAULT |-> $past(alarm_indication_defect) && !$past(I_INCOMING_SF) && $past(mon);
   endproperty
   property p_unmon;
      !mon |=> !O_DEGRADED_FAULT && !O_REMOTE_FAULT;
   endproperty
   property p_ssf_fault;
      O_SERVER_FAIL_FAULT |-> $past(alarm_indication_defect) && $past(ctrl_reg[msoh_pkg::CTRL_SSF]);
   endproperty
   property p_near_ds;
      (alarm_indication_defect || I_EQUIPMENT_DEFECT) |=> O_NEAR_DEFECT_SECOND;
   endproperty
   property p_dcc_ins;
      tx_dcc |=> O_TX_VLD && O_TX_DATA == $past(I_DCC_TX_DATA);
   endproperty
   property p_dcc_ext;
      rx_dcc |=> O_DCC_RX_VLD && O_DCC_RX_DATA == $past(I_RX_DATA);
   endproperty
   property p_e2_idle;
      tx_e2 && !have_reg |=> O_TX_DATA == msoh_pkg::OW_IDLE;
   endproperty
   property p_ais_rise;
      $rose(alarm_indication_defect) |-> $past(rx_k2 && I_RX_DATA[2:0] == msoh_pkg::K2_AIS);
   endproperty
   property p_ow_wr;
      ow_wr_reg |-> $past(ow_edge);
   endproperty

   a_wb_ack:    assert property (p_wb_ack) else $error("Bad ack.");
   a_ais_fault: assert property (p_ais_fault) else $error("Bad alarm fault.");
   a_unmon:     assert property (p_unmon) else $error("Fault while unmonitored.");
   a_ssf_fault: assert property (p_ssf_fault) else $error("Bad server fault.");
   a_near_ds:   assert property (p_near_ds) else $error("Near second missed.");
   a_dcc_ins:   assert property (p_dcc_ins) else $error("Channel not inserted.");
   a_dcc_ext:   assert property (p_dcc_ext) else $error("Channel not extracted.");
   a_e2_idle:   assert property (p_e2_idle) else $error("E2 fill wrong.");
   a_ais_rise:  assert property (p_ais_rise) else $error("Alarm set without K2.");
   a_ow_wr:     assert property (p_ow_wr) else $error("Write off clock.");
endmodule

// ===== msoh_frame_gen.sv
// Behavioural STM-0 frame stream source standing in for the section layer.
`timescale 1ns/1ps
module msoh_frame_gen (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic [2:0] i_k2,
   input  wire logic [7:0] i_e2,
   output logic            o_vld,
   output logic            o_fs,
   output logic [7:0]      o_data,
   output logic [9:0]      o_pos
);
   // Byte position runs over the 9 x 90 frame, one byte every cycle.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pos <= 10'h000;
         o_vld <= 1'b0;
      end else begin
         o_vld <= 1'b1;
         o_pos <= (o_pos == 10'h329 || !o_vld) ? 10'h000 : o_pos + 10'h001;
      end
   end
   assign o_fs   = o_vld && o_pos == 10'h000;
   assign o_data = (o_pos == 10'h16A) ? {5'h00, i_k2} : (o_pos == 10'h2D2) ? i_e2 : o_pos[7:0];
endmodule

// ===== msoh_top_tb_top.sv
// Self-checking testbench for the STM-0 overhead channel block.
`timescale 1ns/1ps
module msoh_top_tb_top;
   logic        I_REF_CLK, I_RESET_N, I_WB_CYC, I_WB_STB, I_WB_WE, O_WB_ACK, O_IRQ;
   logic [7:0]  I_WB_ADR, I_RX_DATA, I_TX_DATA, O_TX_DATA, I_DCC_TX_DATA, O_DCC_RX_DATA;
   logic [31:0] I_WB_DAT, O_WB_DAT, rd;
   logic [3:0]  I_WB_SEL, I_NEAR_BLOCK_ERRORS, I_FAR_BLOCK_ERRORS;
   logic        I_RX_VLD, I_RX_FS, I_TRAIL_SF, I_INCOMING_SF, I_DEGRADED_DEFECT;
   logic        I_EQUIPMENT_DEFECT, I_BLK_VLD, O_ALARM_FAULT, O_DEGRADED_FAULT;
   logic        O_REMOTE_FAULT, O_SERVER_FAIL_FAULT, O_NEAR_DEFECT_SECOND;
   logic        O_FAR_DEFECT_SECOND, O_TRAIL_SF, I_TX_VLD, I_TX_FS, O_TX_VLD, O_DCC_TX_REQ;
   logic        O_DCC_RX_VLD, O_DCC_RX_SF, I_OW_CLK, I_OW_FS, I_OW_DATA;
   logic        O_OW_RX_CLK, O_OW_RX_FS, O_OW_RX_DATA, O_OW_RX_SF, rxe, txe, ow_on;
   logic [7:0]  rxd, txd, ow;
   logic [9:0]  rx_pos, tx_pos;
   logic [5:0]  owc;
   logic [2:0]  k2;
   int          errors, total_checks, cyc, last, gap;
   localparam logic [7:0] OWX = 8'h3C;
   typedef struct packed {
      logic [2:0] k2;
      logic [3:0] ctrl;
      logic [2:0] lvl;
      logic [3:0] flt;
      logic [1:0] ds;
   } row_t;
   row_t rows [8] = '{{3'h0, 4'hF, 3'h2, 4'h2, 2'h0}, {3'h0, 4'hE, 3'h3, 4'h0, 2'h1},
                      {3'h7, 4'hF, 3'h0, 4'h9, 2'h1}, {3'h7, 4'hF, 3'h4, 4'h8, 2'h1},
                      {3'h7, 4'h9, 3'h0, 4'h8, 2'h1}, {3'h7, 4'h3, 3'h2, 4'h3, 2'h1},
                      {3'h6, 4'hF, 3'h0, 4'h4, 2'h2}, {3'h6, 4'hB, 3'h2, 4'h2, 2'h2}};

   msoh_top dut (.*);
   msoh_frame_gen rx_gen (.i_clk(I_REF_CLK), .i_rst_n(I_RESET_N), .i_k2(k2), .i_e2(8'hA5),
      .o_vld(I_RX_VLD), .o_fs(I_RX_FS), .o_data(I_RX_DATA), .o_pos(rx_pos));
   msoh_frame_gen tx_gen (.i_clk(I_REF_CLK), .i_rst_n(I_RESET_N), .i_k2(3'h0), .i_e2(8'h00),
      .o_vld(I_TX_VLD), .o_fs(I_TX_FS), .o_data(I_TX_DATA), .o_pos(tx_pos));

   function automatic logic is_dcc(input logic [9:0] p);
      return p >= 10'h1C2 && p <= 10'h278 && (p % 10'h05A) < 10'h003;
   endfunction

   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      {I_WB_CYC, I_WB_STB, I_WB_WE, I_WB_ADR, I_WB_DAT} <= {2'h3, we, a, d};
      do @(posedge I_REF_CLK); while (O_WB_ACK !== 1'b1);
      r = O_WB_DAT;
      {I_WB_CYC, I_WB_STB} <= 2'h0;
      @(posedge I_REF_CLK);
   endtask

   task automatic tick;
      do @(posedge I_REF_CLK); while (O_OW_RX_CLK !== 1'b1);
   endtask

   task automatic close_out;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   initial begin
      I_REF_CLK = 1'b0;
      forever #2 I_REF_CLK = ~I_REF_CLK;
   end

   // Stream monitors, and an orderwire source sending OWX at one bit per eight cycles.
   always @(posedge I_REF_CLK) begin
      cyc <= cyc + 1;
      if (I_RESET_N) begin
         if (rxe) cmp("dcc_rx", {1'b1, rxd}, {O_DCC_RX_VLD, O_DCC_RX_DATA});
         if (txe) cmp("tx_oh", {1'b1, txd}, {O_TX_VLD, O_TX_DATA});
         if (I_TX_VLD) cmp("dcc_req", is_dcc(tx_pos), O_DCC_TX_REQ);
         cmp("dcc_sf", I_TRAIL_SF, O_DCC_RX_SF);
      end
      rxe <= I_RX_VLD && is_dcc(rx_pos);
      rxd <= I_RX_DATA;
      txe <= I_TX_VLD && (is_dcc(tx_pos) || tx_pos == 10'h2D2);
      txd <= (tx_pos == 10'h2D2) ? (ow_on ? OWX : 8'hFF) : I_DCC_TX_DATA;
      I_DCC_TX_DATA <= I_DCC_TX_DATA + 8'h01;
      owc <= owc + 6'h01;
      I_OW_CLK <= ow_on && owc[2];
      I_OW_FS <= owc[5:3] == 3'h0;
      I_OW_DATA <= OWX[3'h7 - owc[5:3]];
   end

   always @(posedge I_REF_CLK) begin
      if (cyc == 95000) begin
         errors++;
         close_out();
      end
   end

   initial begin
      {I_RESET_N, I_WB_CYC, I_WB_STB, I_WB_WE, I_WB_ADR, I_WB_DAT, I_WB_SEL} = {44'h0, 4'hF};
      {I_TRAIL_SF, I_INCOMING_SF, I_DEGRADED_DEFECT, I_EQUIPMENT_DEFECT, I_BLK_VLD} = 5'h00;
      {I_NEAR_BLOCK_ERRORS, I_FAR_BLOCK_ERRORS, I_DCC_TX_DATA, k2} = 19'h0;
      {I_OW_CLK, I_OW_FS, I_OW_DATA, owc, errors, total_checks, cyc} = '0;
      ow_on = 1'b1;
      repeat (4) @(posedge I_REF_CLK);
      I_RESET_N <= 1'b1;
      @(posedge I_REF_CLK);
      foreach (rows[i]) begin
         if (rows[i].k2 != k2) begin
            k2 <= rows[i].k2;
            repeat (3400) @(posedge I_REF_CLK);
         end
         wb(1'b1, msoh_pkg::ADR_CTRL, {28'h0000000, rows[i].ctrl}, rd);
         {I_INCOMING_SF, I_DEGRADED_DEFECT, I_EQUIPMENT_DEFECT} <= rows[i].lvl;
         repeat (3) @(posedge I_REF_CLK);
         cmp("faults", rows[i].flt, {O_SERVER_FAIL_FAULT, O_REMOTE_FAULT,
             O_DEGRADED_FAULT, O_ALARM_FAULT});
         cmp("ds", rows[i].ds, {O_FAR_DEFECT_SECOND, O_NEAR_DEFECT_SECOND});
         cmp("trail_sf", k2 == 3'h7, O_TRAIL_SF);
         wb(1'b0, msoh_pkg::ADR_FAULT, 32'h0, rd);
         cmp("fault_reg", {k2 == 3'h6, k2 == 3'h7, rows[i].flt}, rd[5:0]);
      end
      {I_NEAR_BLOCK_ERRORS, I_FAR_BLOCK_ERRORS, I_BLK_VLD} <= 9'h1F1;
      repeat (2) @(posedge I_REF_CLK);
      I_BLK_VLD <= 1'b0;
      wb(1'b0, msoh_pkg::ADR_NEAR_EBC, 32'h0, rd);
      cmp("near_ebc", 32'h0000001E, rd);
      wb(1'b0, msoh_pkg::ADR_FAR_EBC, 32'h0, rd);
      cmp("far_ebc", 32'h00000010, rd);
      wb(1'b0, msoh_pkg::ADR_NEAR_EBC, 32'h0, rd);
      cmp("near_ebc_clr", 32'h00000000, rd);
      wb(1'b0, 8'h1C, 32'h0, rd);
      cmp("unmapped", 32'h00000000, rd);
      cmp("irq_masked", 1'b0, O_IRQ);
      wb(1'b1, msoh_pkg::ADR_MASK, 32'h00000010, rd);
      cmp("irq_slip", 1'b1, O_IRQ);
      wb(1'b0, msoh_pkg::ADR_IRQ, 32'h0, rd);
      cmp("irq_reg", 1'b1, rd[msoh_pkg::IRQ_SLIP]);
      cmp("irq_faults", 4'hF, rd[3:0]);
      wb(1'b1, msoh_pkg::ADR_MASK, 32'h00000000, rd);
      cmp("irq_off", 1'b0, O_IRQ);
      wb(1'b0, msoh_pkg::ADR_DS, 32'h0, rd);
      cmp("ds_sticky", 2'h3, rd[1:0]);
      wb(1'b0, msoh_pkg::ADR_DS, 32'h0, rd);
      cmp("ds_clr", 2'h2, rd[1:0]);
      {I_RESET_N, ow_on} <= 2'h0;
      repeat (2) @(posedge I_REF_CLK);
      I_RESET_N <= 1'b1;
      @(posedge I_REF_CLK);
      cmp("rst_out", 6'h00, {O_TRAIL_SF, O_WB_ACK, O_SERVER_FAIL_FAULT, O_REMOTE_FAULT,
          O_DEGRADED_FAULT, O_ALARM_FAULT});
      I_WB_SEL <= 4'hE;
      wb(1'b1, msoh_pkg::ADR_CTRL, 32'h0000000F, rd);
      I_WB_SEL <= 4'hF;
      wb(1'b0, msoh_pkg::ADR_CTRL, 32'h0, rd);
      cmp("ctrl_sel", {28'h0000000, msoh_pkg::CTRL_RST}, rd);
      wb(1'b0, msoh_pkg::ADR_FAULT, 32'h0, rd);
      cmp("fault_rst", 32'h00000000, rd);
      do tick(); while (O_OW_RX_FS !== 1'b1);
      ow[7] = O_OW_RX_DATA;
      last = cyc;
      for (int b = 6; b >= 0; b--) begin
         tick();
         ow[b] = O_OW_RX_DATA;
         gap = cyc - last;
         last = cyc;
      end
      cmp("ow_octet", 8'hA5, ow);
      cmp("ow_period", {20'h00000, msoh_pkg::OW_BIT_LAST + 12'h001}, gap);
      I_TRAIL_SF <= 1'b1;
      tick();
      repeat (4) begin
         tick();
         cmp("ow_ais", 2'h3, {O_OW_RX_SF, O_OW_RX_DATA});
      end
      I_TRAIL_SF <= 1'b0;
      tick();
      cmp("ow_sf_clr", 1'b0, O_OW_RX_SF);
      close_out();
   end
endmodule
